// File: include/hpp_pkg.sv
// Shared constants and state types of the host processor port.
// Assumes a 16-bit internal register fabric addressed by word.
package hpp_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 14;
   localparam int WADDR_W = 13;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int AHI_W = 6;
   localparam int CTL_W = 9;

   // ----------------------------------------
   // First control byte layout
   // ----------------------------------------
   localparam int CTL_RW_BIT = 7;
   localparam int CTL_BURST_BIT = 0;
   localparam int CTL_AHI_MSB = 6;
   localparam int CTL_AHI_LSB = 1;

   // ----------------------------------------
   // Indices of the synchronised control pins
   // ----------------------------------------
   localparam int PIN_RD_N = 0;
   localparam int PIN_WR_N = 1;
   localparam int PIN_DSTB_N = 2;
   localparam int PIN_RNW = 3;
   localparam int PIN_WIDTH = 4;
   localparam int PIN_SMODE = 5;
   localparam int PIN_SPI = 6;
   localparam int PIN_ORDER = 7;
   localparam int PIN_SWAP = 8;

   // ----------------------------------------
   // Reset values and steps
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_STEP = 14'h0001;
   localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [CTL_W-1:0] PIN_RST = 9'h007;
   localparam logic [1:0] LANE_LO = 2'h1;
   localparam logic [1:0] LANE_HI = 2'h2;
   localparam logic [1:0] LANE_BOTH = 2'h3;

   // ----------------------------------------
   // State types
   // ----------------------------------------
   typedef enum logic [2:0] {
      HPP_ACC_IDLE = 3'h1,
      HPP_ACC_BUSY = 3'h2,
      HPP_ACC_DONE = 3'h4
   } hpp_acc_state_t;

   typedef enum logic [2:0] {
      HPP_SP_CTL0 = 3'h1,
      HPP_SP_CTL1 = 3'h2,
      HPP_SP_DATA = 3'h4
   } hpp_sp_state_t;

endpackage

// File: design/hpp_spi_link.sv
// Serial shift logic clocked by the master's serial clock.
// Assumes static polarity and phase straps and a chip select from the master.
`timescale 1ns/1ns
module hpp_spi_link (
   // Serial pins
   input wire logic serial_clk_i,
   input wire logic serial_cs_n_i,
   input wire logic serial_mosi_i,
   output logic serial_miso_o,
   output logic serial_miso_oe_o,
   // Straps
   input wire logic serial_polarity_strap_i,
   input wire logic serial_phase_strap_i,
   // Core side
   input wire logic reset_i,
   input wire logic [hpp_pkg::BYTE_W-1:0] tx_byte_i,
   output logic [hpp_pkg::BYTE_W-1:0] rx_byte_o,
   output logic rx_toggle_o
);
   logic link_clk;
   logic [2:0] bit_idx;
   logic [hpp_pkg::BYTE_W-2:0] shift;

   // ----------------------------------------
   // Sampling edge
   // ----------------------------------------
   // Straps are static, so this mux never glitches in operation
   assign link_clk = serial_clk_i ^ (serial_polarity_strap_i ^ serial_phase_strap_i);

   // Chip select release restarts the byte framing
   always_ff @(posedge link_clk or posedge serial_cs_n_i) begin
      if (serial_cs_n_i) begin
         bit_idx <= 3'h0;
         shift <= 7'h00;
      end else begin
         bit_idx <= bit_idx + 3'h1;
         shift <= {shift[hpp_pkg::BYTE_W-3:0], serial_mosi_i};
      end
   end

   // Byte hand-off: toggle marks a completed byte, byte stays put for 8 bits
   always_ff @(posedge link_clk or posedge reset_i) begin
      if (reset_i) begin
         rx_byte_o <= hpp_pkg::BYTE_RST;
         rx_toggle_o <= 1'b0;
      end else if (!serial_cs_n_i && bit_idx == 3'h7) begin
         rx_byte_o <= {shift, serial_mosi_i};
         rx_toggle_o <= !rx_toggle_o;
      end
   end

   // ----------------------------------------
   // Output bit, most significant first
   // ----------------------------------------
   assign serial_miso_o = tx_byte_i[~bit_idx];
   assign serial_miso_oe_o = !serial_cs_n_i;

endmodule

// File: design/hpp_host_port.sv
// Host processor port: parallel bus or slave serial port onto a register fabric.
// Assumes a fabric that answers each request with one ack pulse.
//
// Summary of operation
// - Serial access: two control bytes then one data byte; select may stay.
// - Burst set, select held: no new control bytes, address steps each byte.
// - Burst clear, select held: bytes after each data byte are new control.
// - Any release of select ends a burst in both phase settings.
// - First byte after select is reasserted is a control byte.
// - Phase one also allows many accesses under one select, same rules.
// - Strap sets bit order; read/write flag msb and burst lsb stay fixed.
// - Width pin picks 8 or 16 bits; shared pin is address lsb or swap.
// - Swap pin low no swap, high swap; host keeps it static.
// - Clear-on-read: read of latched status returns it, then zeroes the bits of the byte lanes read.
// - Clear-on-write: write clears only bits written one.
// - Ready output reports completion of each parallel access to a claimed address.
// - Ready stays inactive for addresses owned by no block.
// - Strobe-mode low: read/write pulses; high: data strobe with direction pin.
// - Narrow bus uses address bit zero, upper data byte never driven.
`timescale 1ns/1ns
module hpp_host_port (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Straps and mode pins
   input wire logic spi_mode_i,
   input wire logic serial_polarity_strap_i,
   input wire logic serial_phase_strap_i,
   input wire logic serial_bit_order_strap_i,
   input wire logic width_i,
   input wire logic strobe_mode_i,
   input wire logic latched_clear_mode_sel_i,
   // Serial port
   input wire logic serial_clk_i,
   input wire logic serial_cs_n_i,
   input wire logic serial_mosi_i,
   output logic serial_miso_o,
   output logic serial_miso_oe_o,
   // Parallel port
   input wire logic [hpp_pkg::ADDR_W-1:1] par_addr_i,
   input wire logic addr_lsb_or_byte_swap_pin_i,
   input wire logic [hpp_pkg::DATA_W-1:0] par_data_i,
   output logic [hpp_pkg::DATA_W-1:0] par_data_o,
   output logic [1:0] par_data_oe_o,
   input wire logic read_n_i,
   input wire logic write_n_i,
   input wire logic data_strobe_n_i,
   input wire logic read_not_write_i,
   output logic ready_n_o,
   // Register fabric
   output logic reg_req_o,
   output logic reg_we_o,
   output logic [hpp_pkg::WADDR_W-1:0] reg_addr_o,
   output logic [1:0] reg_be_o,
   output logic [hpp_pkg::DATA_W-1:0] reg_wdata_o,
   input wire logic reg_ack_i,
   input wire logic reg_hit_i,
   input wire logic reg_latched_i,
   input wire logic [hpp_pkg::DATA_W-1:0] reg_rdata_i,
   output logic lat_clr_o,
   output logic [hpp_pkg::DATA_W-1:0] lat_clr_mask_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [hpp_pkg::DATA_W-1:0] swap16(input logic [hpp_pkg::DATA_W-1:0] d);
      swap16 = {d[hpp_pkg::BYTE_W-1:0], d[hpp_pkg::DATA_W-1:hpp_pkg::BYTE_W]};
   endfunction

   function automatic logic [hpp_pkg::BYTE_W-1:0] rev8(input logic [hpp_pkg::BYTE_W-1:0] d);
      for (int i = 0; i < hpp_pkg::BYTE_W; i++) begin
         rev8[i] = d[hpp_pkg::BYTE_W-1-i];
      end
   endfunction

   function automatic logic [hpp_pkg::AHI_W-1:0] rev6(input logic [hpp_pkg::AHI_W-1:0] d);
      for (int i = 0; i < hpp_pkg::AHI_W; i++) begin
         rev6[i] = d[hpp_pkg::AHI_W-1-i];
      end
   endfunction

   function automatic logic [1:0] lanes(input logic wide, input logic a0);
      if (wide) begin
         lanes = hpp_pkg::LANE_BOTH;
      end else if (a0) begin
         lanes = hpp_pkg::LANE_HI;
      end else begin
         lanes = hpp_pkg::LANE_LO;
      end
   endfunction

   function automatic logic [hpp_pkg::DATA_W-1:0] mask16(input logic [1:0] be);
      mask16 = {{hpp_pkg::BYTE_W{be[1]}}, {hpp_pkg::BYTE_W{be[0]}}};
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [hpp_pkg::CTL_W-1:0] pin_meta;
   logic [hpp_pkg::CTL_W-1:0] pin;
   logic [hpp_pkg::ADDR_W-1:1] addr_meta;
   logic [hpp_pkg::ADDR_W-1:1] addr_s;
   logic [hpp_pkg::DATA_W-1:0] data_meta;
   logic [hpp_pkg::DATA_W-1:0] data_s;
   logic [1:0] link_meta;
   logic [1:0] link_s;
   logic tgl_prev;
   logic cs_high;
   logic byte_evt;
   logic [hpp_pkg::BYTE_W-1:0] rx_byte;
   logic rx_toggle;
   logic [hpp_pkg::BYTE_W-1:0] spi_tx_byte;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pin_meta <= hpp_pkg::PIN_RST;
         pin <= hpp_pkg::PIN_RST;
         link_meta <= 2'h1;
         link_s <= 2'h1;
         tgl_prev <= 1'b0;
      end else begin
         pin_meta <= {addr_lsb_or_byte_swap_pin_i, serial_bit_order_strap_i, spi_mode_i,
                      strobe_mode_i, width_i, read_not_write_i, data_strobe_n_i,
                      write_n_i, read_n_i};
         pin <= pin_meta;
         link_meta <= {rx_toggle, serial_cs_n_i};
         link_s <= link_meta;
         tgl_prev <= link_s[1];
      end
   end

   // Bus words are only used once the strobe has passed the same depth
   always_ff @(posedge core_clk_i) begin
      addr_meta <= par_addr_i;
      addr_s <= addr_meta;
      data_meta <= par_data_i;
      data_s <= data_meta;
   end

   assign cs_high = link_s[0];
   assign byte_evt = (link_s[1] != tgl_prev) && pin[hpp_pkg::PIN_SPI];

   // ----------------------------------------
   // Serial link
   // ----------------------------------------
   hpp_spi_link u_link (
      .serial_clk_i(serial_clk_i),
      .serial_cs_n_i(serial_cs_n_i),
      .serial_mosi_i(serial_mosi_i),
      .serial_miso_o(serial_miso_o),
      .serial_miso_oe_o(serial_miso_oe_o),
      .serial_polarity_strap_i(serial_polarity_strap_i),
      .serial_phase_strap_i(serial_phase_strap_i),
      .reset_i(reset_i),
      .tx_byte_i(spi_tx_byte),
      .rx_byte_o(rx_byte),
      .rx_toggle_o(rx_toggle)
   );

   // ----------------------------------------
   // Serial access decoder
   // ----------------------------------------
   hpp_pkg::hpp_sp_state_t sp_state;
   logic sp_rw;
   logic sp_burst;
   logic [hpp_pkg::ADDR_W-1:0] sp_addr;
   logic [hpp_pkg::ADDR_W-1:0] next_sp_addr;
   logic [hpp_pkg::BYTE_W-1:0] rx_ord;
   logic spi_pend;
   logic spi_we;
   logic [hpp_pkg::ADDR_W-1:0] spi_addr;
   logic [hpp_pkg::BYTE_W-1:0] spi_wdata;
   logic acc_take_spi;

   assign rx_ord = pin[hpp_pkg::PIN_ORDER] ? rev8(rx_byte) : rx_byte;
   assign next_sp_addr = sp_addr + hpp_pkg::ADDR_STEP;

   // Same decoder serves both phase settings
   always_ff @(posedge core_clk_i) begin
      if (reset_i || cs_high) begin
         sp_state <= hpp_pkg::HPP_SP_CTL0;
         sp_rw <= 1'b0;
         sp_burst <= 1'b0;
      end else if (byte_evt) begin
         case (sp_state)
            hpp_pkg::HPP_SP_CTL0: begin
               sp_rw <= rx_byte[hpp_pkg::CTL_RW_BIT];
               sp_burst <= rx_byte[hpp_pkg::CTL_BURST_BIT];
               sp_state <= hpp_pkg::HPP_SP_CTL1;
            end
            hpp_pkg::HPP_SP_CTL1: begin
               sp_state <= hpp_pkg::HPP_SP_DATA;
            end
            hpp_pkg::HPP_SP_DATA: begin
               if (!sp_burst) begin
                  sp_state <= hpp_pkg::HPP_SP_CTL0;
               end
            end
            default: begin
               sp_state <= hpp_pkg::HPP_SP_CTL0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sp_addr <= hpp_pkg::ADDR_RST;
      end else if (byte_evt && !cs_high) begin
         if (sp_state == hpp_pkg::HPP_SP_CTL0) begin
            sp_addr[hpp_pkg::ADDR_W-1:hpp_pkg::BYTE_W] <= pin[hpp_pkg::PIN_ORDER] ?
               rev6(rx_byte[hpp_pkg::CTL_AHI_MSB:hpp_pkg::CTL_AHI_LSB]) :
               rx_byte[hpp_pkg::CTL_AHI_MSB:hpp_pkg::CTL_AHI_LSB];
         end else if (sp_state == hpp_pkg::HPP_SP_CTL1) begin
            sp_addr[hpp_pkg::BYTE_W-1:0] <= rx_ord;
         end else if (sp_state == hpp_pkg::HPP_SP_DATA && sp_burst) begin
            sp_addr <= next_sp_addr;
         end
      end
   end

   // Pending fabric request from the serial side; a read is fetched ahead of its data byte
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         spi_pend <= 1'b0;
         spi_we <= 1'b0;
         spi_addr <= hpp_pkg::ADDR_RST;
         spi_wdata <= hpp_pkg::BYTE_RST;
      end else if (byte_evt && !cs_high && sp_state == hpp_pkg::HPP_SP_CTL1 && sp_rw) begin
         spi_pend <= 1'b1;
         spi_we <= 1'b0;
         spi_addr <= {sp_addr[hpp_pkg::ADDR_W-1:hpp_pkg::BYTE_W], rx_ord};
      // Last data byte may be seen with the select release; it is still written
      end else if (byte_evt && sp_state == hpp_pkg::HPP_SP_DATA && !sp_rw) begin
         spi_pend <= 1'b1;
         spi_we <= 1'b1;
         spi_addr <= sp_addr;
         spi_wdata <= rx_ord;
      end else if (byte_evt && !cs_high && sp_state == hpp_pkg::HPP_SP_DATA && sp_burst) begin
         spi_pend <= 1'b1;
         spi_we <= 1'b0;
         spi_addr <= next_sp_addr;
      end else if (acc_take_spi) begin
         spi_pend <= 1'b0;
      end
   end

   // ----------------------------------------
   // Parallel strobe decode
   // ----------------------------------------
   logic par_strobe;
   logic par_write;
   logic wide;

   assign wide = pin[hpp_pkg::PIN_WIDTH];
   always_comb begin
      if (pin[hpp_pkg::PIN_SMODE]) begin
         par_strobe = !pin[hpp_pkg::PIN_DSTB_N];
         par_write = !pin[hpp_pkg::PIN_RNW];
      end else begin
         par_strobe = !pin[hpp_pkg::PIN_RD_N] || !pin[hpp_pkg::PIN_WR_N];
         par_write = !pin[hpp_pkg::PIN_WR_N];
      end
   end

   // ----------------------------------------
   // Fabric access sequencer
   // ----------------------------------------
   hpp_pkg::hpp_acc_state_t acc_state;
   logic acc_spi;
   logic acc_wide;
   logic acc_swap;
   logic acc_hit;
   logic [hpp_pkg::ADDR_W-1:0] acc_addr;
   logic acc_start_par;
   logic acc_ack;

   assign acc_take_spi = acc_state == hpp_pkg::HPP_ACC_IDLE && spi_pend && pin[hpp_pkg::PIN_SPI];
   assign acc_start_par = acc_state == hpp_pkg::HPP_ACC_IDLE && par_strobe && !pin[hpp_pkg::PIN_SPI];
   assign acc_ack = acc_state == hpp_pkg::HPP_ACC_BUSY && reg_ack_i;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         acc_state <= hpp_pkg::HPP_ACC_IDLE;
         acc_spi <= 1'b0;
         acc_wide <= 1'b0;
         acc_swap <= 1'b0;
         acc_hit <= 1'b0;
         acc_addr <= hpp_pkg::ADDR_RST;
         reg_req_o <= 1'b0;
         reg_we_o <= 1'b0;
         reg_wdata_o <= hpp_pkg::DATA_RST;
      end else begin
         reg_req_o <= 1'b0;
         case (acc_state)
            hpp_pkg::HPP_ACC_IDLE: begin
               if (acc_take_spi) begin
                  acc_state <= hpp_pkg::HPP_ACC_BUSY;
                  acc_spi <= 1'b1;
                  acc_wide <= 1'b0;
                  acc_swap <= 1'b0;
                  acc_addr <= spi_addr;
                  reg_req_o <= 1'b1;
                  reg_we_o <= spi_we;
                  reg_wdata_o <= {spi_wdata, spi_wdata};
               end else if (acc_start_par) begin
                  acc_state <= hpp_pkg::HPP_ACC_BUSY;
                  acc_spi <= 1'b0;
                  acc_wide <= wide;
                  acc_swap <= wide && pin[hpp_pkg::PIN_SWAP];
                  acc_addr <= {addr_s, wide ? 1'b0 : pin[hpp_pkg::PIN_SWAP]};
                  reg_req_o <= 1'b1;
                  reg_we_o <= par_write;
                  if (!wide) begin
                     reg_wdata_o <= {2{data_s[hpp_pkg::BYTE_W-1:0]}};
                  end else if (pin[hpp_pkg::PIN_SWAP]) begin
                     reg_wdata_o <= swap16(data_s);
                  end else begin
                     reg_wdata_o <= data_s;
                  end
               end
            end
            hpp_pkg::HPP_ACC_BUSY: begin
               if (reg_ack_i) begin
                  acc_hit <= reg_hit_i;
                  acc_state <= acc_spi ? hpp_pkg::HPP_ACC_IDLE : hpp_pkg::HPP_ACC_DONE;
               end
            end
            hpp_pkg::HPP_ACC_DONE: begin
               // Cycle ends only when the host drops its strobe
               if (!par_strobe) begin
                  acc_state <= hpp_pkg::HPP_ACC_IDLE;
                  acc_hit <= 1'b0;
               end
            end
            default: begin
               acc_state <= hpp_pkg::HPP_ACC_IDLE;
            end
         endcase
      end
   end

   assign reg_addr_o = acc_addr[hpp_pkg::ADDR_W-1:1];
   assign reg_be_o = lanes(acc_wide, acc_addr[0]);

   // Ready only for addresses some block claims
   assign ready_n_o = !(acc_state == hpp_pkg::HPP_ACC_DONE && acc_hit);

   // ----------------------------------------
   // Read data return
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         par_data_o <= hpp_pkg::DATA_RST;
         spi_tx_byte <= hpp_pkg::BYTE_RST;
      end else if (acc_ack && !reg_we_o) begin
         if (acc_spi) begin
            spi_tx_byte <= pin[hpp_pkg::PIN_ORDER] ? rev8(acc_addr[0] ?
               reg_rdata_i[hpp_pkg::DATA_W-1:hpp_pkg::BYTE_W] :
               reg_rdata_i[hpp_pkg::BYTE_W-1:0]) : (acc_addr[0] ?
               reg_rdata_i[hpp_pkg::DATA_W-1:hpp_pkg::BYTE_W] :
               reg_rdata_i[hpp_pkg::BYTE_W-1:0]);
         end else if (!acc_wide) begin
            par_data_o <= {hpp_pkg::BYTE_RST, acc_addr[0] ?
               reg_rdata_i[hpp_pkg::DATA_W-1:hpp_pkg::BYTE_W] :
               reg_rdata_i[hpp_pkg::BYTE_W-1:0]};
         end else begin
            par_data_o <= acc_swap ? swap16(reg_rdata_i) : reg_rdata_i;
         end
      end
   end

   // Upper lane stays undriven on a narrow bus
   assign par_data_oe_o = (acc_state == hpp_pkg::HPP_ACC_DONE && !acc_spi && !reg_we_o &&
                           par_strobe) ? {acc_wide, 1'b1} : 2'h0;

   // ----------------------------------------
   // Latched status clearing
   // ----------------------------------------
   // The status owner lets a new event win over this clear
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         lat_clr_o <= 1'b0;
         lat_clr_mask_o <= hpp_pkg::DATA_RST;
      end else if (acc_ack && reg_latched_i && !reg_we_o && latched_clear_mode_sel_i) begin
         lat_clr_o <= 1'b1;
         lat_clr_mask_o <= mask16(reg_be_o);
      end else if (acc_ack && reg_latched_i && reg_we_o && !latched_clear_mode_sel_i) begin
         lat_clr_o <= 1'b1;
         lat_clr_mask_o <= reg_wdata_o & mask16(reg_be_o);
      end else begin
         lat_clr_o <= 1'b0;
         lat_clr_mask_o <= hpp_pkg::DATA_RST;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   burst_addr_step_a: assert property (
      byte_evt && !cs_high && sp_state == hpp_pkg::HPP_SP_DATA && sp_burst
      |=> sp_addr == $past(sp_addr) + hpp_pkg::ADDR_STEP)
      else $error("burst address did not step");
   single_ctl_next_a: assert property (
      byte_evt && !cs_high && sp_state == hpp_pkg::HPP_SP_DATA && !sp_burst
      |=> sp_state == hpp_pkg::HPP_SP_CTL0)
      else $error("non-burst data byte not followed by control");
   cs_release_end_a: assert property (
      cs_high |=> sp_state == hpp_pkg::HPP_SP_CTL0 && !sp_burst)
      else $error("select release did not end access");
   ctl_flag_pos_a: assert property (
      byte_evt && !cs_high && sp_state == hpp_pkg::HPP_SP_CTL0
      |=> sp_rw == $past(rx_byte[hpp_pkg::CTL_RW_BIT])
          && sp_burst == $past(rx_byte[hpp_pkg::CTL_BURST_BIT]))
      else $error("control flags taken from wrong bits");
   narrow_upper_a: assert property (
      !acc_wide |-> !par_data_oe_o[1])
      else $error("upper byte driven on narrow bus");
   ready_hit_a: assert property (
      acc_ack && reg_hit_i && !acc_spi |=> !ready_n_o)
      else $error("ready missing after mapped access");
   ready_unmapped_a: assert property (
      acc_ack && !reg_hit_i |=> ready_n_o [*2])
      else $error("ready asserted for unmapped address");
   read_clear_a: assert property (
      acc_ack && !reg_we_o && reg_latched_i && latched_clear_mode_sel_i
      |=> lat_clr_o && lat_clr_mask_o == mask16($past(reg_be_o)))
      else $error("clear on read missing");
   write_clear_a: assert property (
      acc_ack && reg_we_o && reg_latched_i && !latched_clear_mode_sel_i
      |=> lat_clr_o && lat_clr_mask_o == ($past(reg_wdata_o) & mask16($past(reg_be_o))))
      else $error("clear on write mask wrong");
   spi_read_fetch_a: assert property (
      byte_evt && !cs_high && sp_state == hpp_pkg::HPP_SP_CTL1 && sp_rw
      |=> spi_pend ##[1:2] reg_req_o)
      else $error("serial read not fetched");

   burst_seen_c: cover property (byte_evt && sp_state == hpp_pkg::HPP_SP_DATA && sp_burst);
   par_read_c: cover property (acc_ack && !acc_spi && !reg_we_o && reg_hit_i);
   lat_clear_c: cover property (lat_clr_o);

endmodule

// File: bench/hpp_fabric_model.sv
// Register fabric stand-in: 64-word memory, ack two core cycles after each request.
// Assumes word addresses from 13'h1000 up belong to no block.
`timescale 1ns/1ns
module hpp_fabric_model (
   // Fabric side
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [12:0] addr_i,
   input wire logic [1:0] be_i,
   input wire logic [15:0] wdata_i,
   output logic ack_o,
   output logic hit_o,
   output logic latched_o,
   output logic [15:0] rdata_o
);
   logic [15:0] mem [0:63];
   logic req_d;
   always_ff @(posedge clk_i) begin
      req_d <= req_i;
      ack_o <= req_d;
      hit_o <= addr_i < 13'h1000;
      latched_o <= addr_i == 13'h0030;
      rdata_o <= mem[addr_i[5:0]];
      if (req_i && we_i && addr_i < 13'h1000 && be_i[0]) mem[addr_i[5:0]][7:0] <= wdata_i[7:0];
      if (req_i && we_i && addr_i < 13'h1000 && be_i[1]) mem[addr_i[5:0]][15:8] <= wdata_i[15:8];
   end
endmodule

// File: bench/tb_hpp_host_port.sv
// Bench for the host port: parallel accesses in both strobe modes, swap, two serial writes.
// Assumes the fabric model answers every request.
`timescale 1ns/1ns
module tb_hpp_host_port;
   logic clk = 1'b0, rst = 1'b1, spi = 1'b0, swap = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
   logic sclk = 1'b0, cs_n = 1'b1, mosi = 1'b0, seen = 1'b0, smode = 1'b0, clrm = 1'b0;
   logic wid = 1'b1, pol = 1'b0, pha = 1'b0, ord = 1'b0, miso;
   logic [1:0] oe;
   logic [7:0] srx;
   logic [12:0] addr = 13'h0000;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] mem_m [0:63];
   logic req, we, ack, hit, lat, rdy_n;
   logic [12:0] raddr;
   logic [1:0] be;
   logic [15:0] rdata, pdo, rwd;
   logic [15:0] exp_q [$];
   int n_fail = 0, total_checks = 0;
   hpp_host_port i_hpp_host_port (.core_clk_i(clk), .reset_i(rst), .spi_mode_i(spi),
      .serial_polarity_strap_i(pol), .serial_phase_strap_i(pha),
      .serial_bit_order_strap_i(ord), .width_i(wid), .strobe_mode_i(smode),
      .latched_clear_mode_sel_i(clrm), .serial_clk_i(sclk), .serial_cs_n_i(cs_n),
      .serial_mosi_i(mosi), .serial_miso_o(miso), .serial_miso_oe_o(), .par_addr_i(addr),
      .addr_lsb_or_byte_swap_pin_i(swap), .par_data_i(wdata), .par_data_o(pdo),
      .par_data_oe_o(oe), .read_n_i(rd_n), .write_n_i(wr_n), .data_strobe_n_i(rd_n & wr_n),
      .read_not_write_i(wr_n), .ready_n_o(rdy_n), .reg_req_o(req), .reg_we_o(we),
      .reg_addr_o(raddr), .reg_be_o(be), .reg_wdata_o(rwd), .reg_ack_i(ack),
      .reg_hit_i(hit), .reg_latched_i(lat), .reg_rdata_i(rdata), .lat_clr_o(),
      .lat_clr_mask_o());
   hpp_fabric_model i_hpp_fabric_model (.clk_i(clk), .req_i(req), .we_i(we), .addr_i(raddr),
      .be_i(be), .wdata_i(rwd), .ack_o(ack), .hit_o(hit), .latched_o(lat), .rdata_o(rdata));
   initial forever #20 clk = ~clk;
   function automatic logic [15:0] sw(input logic [15:0] x, input logic s);
      return s ? {x[7:0], x[15:8]} : x;
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Expected read data is queued here, compared by the monitor below
   task automatic acc(input logic rd, input logic [12:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      if (rd) rd_n <= 1'b0;
      else wr_n <= 1'b0;
      if (!rd && wid) mem_m[a[5:0]] = sw(d, swap);
      else if (!rd) mem_m[a[5:0]][swap*8 +: 8] = d[7:0];
      else if (a < 13'h1000) exp_q.push_back(wid ? sw(mem_m[a[5:0]], swap) :
         {8'h00, mem_m[a[5:0]][swap*8 +: 8]});
      for (int i = 0; i < 30 && rdy_n !== 1'b0; i++) @(posedge clk);
      check({15'h0000, rdy_n}, {15'h0000, a >= 13'h1000});
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   task automatic sbyte(input logic [7:0] b);
      for (int k = 7; k >= 0; k--) begin
         // Data moves just after the trailing edge, clear of the sampling edge
         #5 mosi = b[k];
         srx[k] = miso;
         #10 sclk = ~sclk;
         #15 sclk = ~sclk;
      end
   endtask
   // Master side of one access; select stays low throughout
   task automatic sacc(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] d);
      sbyte(c0);
      sbyte(c1);
      repeat (12) @(posedge clk);
      sbyte(d);
      repeat (12) @(posedge clk);
   endtask
   always @(posedge clk) begin
      if (rdy_n === 1'b0 && !seen && rd_n === 1'b0 && exp_q.size() > 0) begin
         check(pdo, exp_q.pop_front());
         check({14'h0000, oe}, {14'h0000, wid, 1'b1});
      end
      seen <= rdy_n === 1'b0;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      void'($urandom(77117));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int m = 0; m < 2; m++) begin
         smode <= m[0];
         clrm <= m[0];
         swap <= 1'b0;
         repeat (5) @(posedge clk);
         for (int j = 0; j < 4; j++) acc(1'b0, 13'(j), 16'($urandom));
         for (int j = 0; j < 4; j++) acc(1'b1, 13'(j), 16'h0000);
         swap <= 1'b1;
         repeat (5) @(posedge clk);
         acc(1'b0, 13'h0005, 16'($urandom));
         acc(1'b1, 13'h0005, 16'h0000);
         acc(1'b1, 13'h0001, 16'h0000);
         acc(1'b1, 13'h1234, 16'h0000);
         $display("parallel pass %0d done", m);
      end
      wid <= 1'b0;
      for (int j = 0; j < 4; j++) begin
         swap <= j[0];
         repeat (3) @(posedge clk);
         acc(j[1], 13'h0009, 16'($urandom));
      end
      wid <= 1'b1;
      $display("narrow bus test done");
      // Serial write of one byte to the low lane of word 3, read back both ways
      spi <= 1'b1;
      swap <= 1'b0;
      repeat (5) @(posedge clk);
      #7 cs_n = 1'b0;
      sacc(8'h00, 8'h06, 8'h5a);
      #15 cs_n = 1'b1;
      mem_m[3][7:0] = 8'h5a;
      repeat (10) @(posedge clk);
      #7 cs_n = 1'b0;
      sacc(8'h80, 8'h06, 8'h00);
      check({8'h00, srx}, {8'h00, mem_m[3][7:0]});
      #15 cs_n = 1'b1;
      repeat (5) @(posedge clk);
      // Clock idles high, lsb-first order; write then read under one select
      pol <= 1'b1;
      pha <= 1'b1;
      ord <= 1'b1;
      sclk = 1'b1;
      repeat (5) @(posedge clk);
      #7 cs_n = 1'b0;
      sacc(8'h00, 8'h10, 8'hac);
      sacc(8'h80, 8'h10, 8'h00);
      check({8'h00, srx}, 16'h00ac);
      #15 cs_n = 1'b1;
      repeat (10) @(posedge clk);
      spi <= 1'b0;
      repeat (5) @(posedge clk);
      acc(1'b1, 13'h0003, 16'h0000);
      $display("serial write test done");
      print_verdict();
   end
   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end
endmodule
